// ===== pcsm_bridge_model.sv
module pcsm_bridge_model #(
	parameter int PER = 120,
	parameter int WINP = 4
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Scenario control
	input wire logic [2:0] imb_sel,
	input wire logic [7:0] imb_len,
	input wire logic cur_en,
	// Bridge side
	output logic [2:0] phase_imbalance,
	output logic current_high,
	output logic pwm_tick,
	output logic win_tick
);
	logic [7:0] cnt_r;
	logic [3:0] per_r;
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			cnt_r <= 8'h00;
			per_r <= 4'h0;
		end else begin
			cnt_r <= pwm_tick ? 8'h00 : cnt_r + 8'h01;
			if (pwm_tick)
				per_r <= win_tick ? 4'h0 : per_r + 4'h1;
		end
	end
	assign pwm_tick = cnt_r == 8'(PER - 1);
	assign win_tick = pwm_tick && per_r == 4'(WINP - 1);
	// High only early in a period, so a window edge never splits an event
	assign phase_imbalance = (cnt_r < imb_len) ? imb_sel : 3'h0;
	assign current_high = cur_en;
endmodule : pcsm_bridge_model

// ===== pcsm_params.svh
`ifndef PCSM_PARAMS_SVH
`define PCSM_PARAMS_SVH
// Notes on behaviour
// - Action 0 none, 1 warning, 2 trip; trip after reset
// - U phase failure reports warning 139 or trip 207
// - V phase failure reports warning 140 or trip 208
// - W phase failure reports warning 141 or trip 209
// - Raise only when sharing fails while current is high
// - Sharing disable stops active sharing, detection keeps running
// - First-level error after threshold consecutive PWM periods with events
// - Detection after threshold 100 ms periods each with first-level error
// - Readable count of 100 ms periods with first-level errors
// - Duration code n gives (n+1) times 0.4 us

// ****************
// Register map
// ****************
`define PCSM_OFF_CTRL 8'h00
`define PCSM_OFF_PWM_THR 8'h04
`define PCSM_OFF_WIN_THR 8'h08
`define PCSM_OFF_DUR 8'h0C
`define PCSM_OFF_COUNT 8'h10
`define PCSM_OFF_STATUS 8'h14
`define PCSM_OFF_MASK 8'h18
`define PCSM_OFF_CODE 8'h1C

// ****************
// Fields and reset values
// ****************
`define PCSM_CTRL_ACT_LSB 0
`define PCSM_CTRL_DIS_BIT 2
`define PCSM_ACT_NONE 2'h0
`define PCSM_ACT_WARN 2'h1
`define PCSM_ACT_TRIP 2'h2
`define PCSM_RST_PWM_THR 8'h04
`define PCSM_RST_WIN_THR 8'h03
`define PCSM_RST_DUR 4'h0
`define PCSM_STAT_TRIP_LSB 3

// ****************
// Report codes
// ****************
`define PCSM_WARN_U 8'd139
`define PCSM_WARN_V 8'd140
`define PCSM_WARN_W 8'd141
`define PCSM_TRIP_U 8'd207
`define PCSM_TRIP_V 8'd208
`define PCSM_TRIP_W 8'd209

// ****************
// Timing
// ****************
`define PCSM_CLK_PS 8000
`define PCSM_DUR_STEP_PS 400000
`define PCSM_DUR_STEP_CYC ((`PCSM_DUR_STEP_PS + `PCSM_CLK_PS - 1) / `PCSM_CLK_PS)
`endif

// ===== pcsm_phase.sv
`include "pcsm_params.svh"
module pcsm_phase #(
	parameter int CW = 8
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Phase inputs
	input wire logic imb,
	input wire logic pwm_tick,
	input wire logic win_tick,
	input wire logic [9:0] dur_cyc,
	input wire pcsm_pkg::pcsm_cfg_t cfg,
	// Results
	output logic lvl1_win,
	output logic detect
);
	import pcsm_pkg::*;
	if (CW < 8 || CW > 16) begin : g_bad_cw
		$error("CW must be 8 to 16");
	end

	logic [9:0] dur_r;
	logic ev_seen_r;
	logic [CW-1:0] run_r;
	logic lvl1_r;
	logic [CW-1:0] win_r;
	wire ev_now = imb && (dur_r + 10'h001 >= dur_cyc);
	wire had_ev = ev_seen_r || ev_now;
	wire [CW-1:0] run_nxt = had_ev ? (&run_r ? run_r : run_r + 1'b1) : '0;
	wire lvl1_now = pwm_tick && had_ev && (run_nxt >= CW'(cfg.pwm_thr));
	wire had_l1 = lvl1_r || lvl1_now;
	wire [CW-1:0] win_nxt = had_l1 ? (&win_r ? win_r : win_r + 1'b1) : '0;
	assign lvl1_win = had_l1;
	assign detect = win_tick && had_l1 && (win_nxt >= CW'(cfg.win_thr));

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			dur_r <= '0;
			ev_seen_r <= 1'b0;
			run_r <= '0;
			lvl1_r <= 1'b0;
			win_r <= '0;
		end else begin
			// Saturate so a long imbalance gives one event per period
			dur_r <= !imb ? '0 : (ev_now ? dur_r : dur_r + 10'h001);
			ev_seen_r <= pwm_tick ? 1'b0 : had_ev;
			if (pwm_tick)
				run_r <= run_nxt;
			lvl1_r <= win_tick ? 1'b0 : had_l1;
			if (win_tick)
				win_r <= win_nxt;
		end
	end

	// ****************
	// Checks
	// ****************
	sequence s_quiet_period;
		pwm_tick && !had_ev;
	endsequence
	a_run_clear: assert property (@(posedge mclk) disable iff (!rstn)
		s_quiet_period |=> run_r == '0) else $error("run count not cleared");
	a_lvl1_thresh: assert property (@(posedge mclk) disable iff (!rstn)
		pwm_tick && had_ev && run_nxt < CW'(cfg.pwm_thr) && !lvl1_r |-> !lvl1_win)
		else $error("first level raised below threshold");
	a_detect_tick: assert property (@(posedge mclk) disable iff (!rstn)
		detect |-> win_tick && win_nxt >= CW'(cfg.win_thr)) else $error("detect off tick");
	a_dur_event: assert property (@(posedge mclk) disable iff (!rstn)
		$rose(imb) && dur_cyc > 10'd2 |-> !ev_now ##1 !ev_now) else $error("event too early");
endmodule : pcsm_phase

// ===== pcsm_pkg.sv
package pcsm_pkg;
	typedef struct packed {
		logic [1:0] action;
		logic dis;
		logic [7:0] pwm_thr;
		logic [7:0] win_thr;
		logic [3:0] dur;
	} pcsm_cfg_t;
	typedef struct packed {
		logic [2:0] trip;
		logic [2:0] warn;
	} pcsm_stat_t;
	typedef enum logic [1:0] {
		PCSM_WR_IDLE = 2'b00,
		PCSM_WR_RESP = 2'b01
	} pcsm_wr_t;
endpackage : pcsm_pkg

// ===== pcsm_top.sv
`include "pcsm_params.svh"
module pcsm_top #(
	parameter int CW = 8,
	parameter int NCNT = 16
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Power bridge side
	input wire logic [2:0] phase_imbalance,
	input wire logic current_high,
	input wire logic pwm_tick,
	input wire logic win_tick,
	output logic [2:0] share_drive,
	// Drive reporting
	output logic sharing_warning,
	output logic sharing_trip,
	output logic [7:0] report_code,
	output logic irq
);
	import pcsm_pkg::*;
	if (NCNT < 8 || NCNT > 32) begin : g_bad_ncnt
		$error("NCNT must be 8 to 32");
	end

	// ****************
	// Input synchronisers
	// ****************
	logic [3:0] pin_meta_r;
	logic [3:0] pin_sync_r;
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end else begin
			pin_meta_r <= {current_high, phase_imbalance};
			pin_sync_r <= pin_meta_r;
		end
	end
	wire [2:0] imb_s = pin_sync_r[2:0];
	wire cur_high_s = pin_sync_r[3];

	// ****************
	// Configuration and status registers
	// ****************
	pcsm_cfg_t cfg_r;
	pcsm_stat_t stat_r;
	pcsm_stat_t mask_r;
	logic [NCNT-1:0] count_r;
	logic [7:0] code_r;
	logic [2:0] share_r;

	// ****************
	// Per-phase qualification
	// ****************
	// Step count fits ten bits: 16 steps of 50 cycles
	wire [9:0] dur_cyc = 10'(({6'h00, cfg_r.dur} + 10'h001) * 10'(`PCSM_DUR_STEP_CYC));
	wire [2:0] lvl1_win;
	wire [2:0] detect;
	genvar gp;
	generate
		for (gp = 0; gp < 3; gp++) begin : g_phase
			pcsm_phase #(.CW(CW)) u_phase (
				.mclk(mclk),
				.rstn(rstn),
				.imb(imb_s[gp]),
				.pwm_tick(pwm_tick),
				.win_tick(win_tick),
				.dur_cyc(dur_cyc),
				.cfg(cfg_r),
				.lvl1_win(lvl1_win[gp]),
				.detect(detect[gp])
			);
		end
	endgenerate

	// ****************
	// Action selection
	// ****************
	// Low current mis-sharing cannot stress the remaining modules
	wire [2:0] fail = detect & {3{cur_high_s}};
	wire act_warn = cfg_r.action == `PCSM_ACT_WARN;
	wire act_trip = cfg_r.action == `PCSM_ACT_TRIP;
	wire [2:0] set_warn = fail & {3{act_warn}};
	wire [2:0] set_trip = fail & {3{act_trip}};
	wire any_set = |(set_warn | set_trip);
	// Lowest phase wins when phases fail in the same tick
	wire [7:0] warn_code = fail[0] ? `PCSM_WARN_U :
		fail[1] ? `PCSM_WARN_V : `PCSM_WARN_W;
	wire [7:0] trip_code = fail[0] ? `PCSM_TRIP_U :
		fail[1] ? `PCSM_TRIP_V : `PCSM_TRIP_W;
	wire [7:0] code_nxt = act_trip ? trip_code : warn_code;
	wire cnt_inc = win_tick && (|lvl1_win) && !(&count_r);

	// ****************
	// AXI4-Lite write path
	// ****************
	pcsm_wr_t wst_r;
	logic aw_got_r;
	logic w_got_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic [1:0] bresp_r;
	wire aw_hs = s_axi_awvalid && s_axi_awready;
	wire w_hs = s_axi_wvalid && s_axi_wready;
	wire have_aw = aw_got_r || aw_hs;
	wire have_w = w_got_r || w_hs;
	wire do_wr = (wst_r == PCSM_WR_IDLE) && have_aw && have_w;
	wire [7:0] wa = aw_got_r ? aw_addr_r : s_axi_awaddr;
	wire [31:0] wd = w_got_r ? w_data_r : s_axi_wdata;
	wire [3:0] ws = w_got_r ? w_strb_r : s_axi_wstrb;
	wire wb0 = do_wr && ws[0];
	wire wr_ctrl = wb0 && (wa == `PCSM_OFF_CTRL);
	wire wr_pthr = wb0 && (wa == `PCSM_OFF_PWM_THR);
	wire wr_wthr = wb0 && (wa == `PCSM_OFF_WIN_THR);
	wire wr_dur = wb0 && (wa == `PCSM_OFF_DUR);
	wire wr_stat = wb0 && (wa == `PCSM_OFF_STATUS);
	wire wr_mask = wb0 && (wa == `PCSM_OFF_MASK);
	wire wa_ok = (wa == `PCSM_OFF_CTRL) || (wa == `PCSM_OFF_PWM_THR) ||
		(wa == `PCSM_OFF_WIN_THR) || (wa == `PCSM_OFF_DUR) ||
		(wa == `PCSM_OFF_COUNT) || (wa == `PCSM_OFF_STATUS) ||
		(wa == `PCSM_OFF_MASK) || (wa == `PCSM_OFF_CODE);
	wire [5:0] w1c = wr_stat ? wd[5:0] : 6'h00;
	assign s_axi_awready = (wst_r == PCSM_WR_IDLE) && !aw_got_r;
	assign s_axi_wready = (wst_r == PCSM_WR_IDLE) && !w_got_r;
	assign s_axi_bvalid = wst_r == PCSM_WR_RESP;
	assign s_axi_bresp = bresp_r;

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			wst_r <= PCSM_WR_IDLE;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= '0;
			w_strb_r <= '0;
			bresp_r <= 2'h0;
		end else begin
			case (wst_r)
				PCSM_WR_IDLE: begin
					if (do_wr) begin
						wst_r <= PCSM_WR_RESP;
						aw_got_r <= 1'b0;
						w_got_r <= 1'b0;
						bresp_r <= wa_ok ? 2'h0 : 2'h2;
					end else begin
						if (aw_hs) begin
							aw_got_r <= 1'b1;
							aw_addr_r <= s_axi_awaddr;
						end
						if (w_hs) begin
							w_got_r <= 1'b1;
							w_data_r <= s_axi_wdata;
							w_strb_r <= s_axi_wstrb;
						end
					end
				end
				PCSM_WR_RESP: begin
					if (s_axi_bready)
						wst_r <= PCSM_WR_IDLE;
				end
				default: wst_r <= PCSM_WR_IDLE;
			endcase
		end
	end

	// ****************
	// Register state
	// ****************
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			cfg_r.action <= `PCSM_ACT_TRIP;
			cfg_r.dis <= 1'b0;
			cfg_r.pwm_thr <= `PCSM_RST_PWM_THR;
			cfg_r.win_thr <= `PCSM_RST_WIN_THR;
			cfg_r.dur <= `PCSM_RST_DUR;
			stat_r <= '0;
			mask_r <= '0;
			count_r <= '0;
			code_r <= '0;
			share_r <= '0;
		end else begin
			if (wr_ctrl) begin
				cfg_r.action <= wd[`PCSM_CTRL_ACT_LSB +: 2];
				cfg_r.dis <= wd[`PCSM_CTRL_DIS_BIT];
			end
			if (wr_pthr)
				cfg_r.pwm_thr <= wd[7:0];
			if (wr_wthr)
				cfg_r.win_thr <= wd[7:0];
			if (wr_dur)
				cfg_r.dur <= wd[3:0];
			if (wr_mask)
				mask_r <= wd[5:0];
			// A new failure outlives a clear in the same cycle
			stat_r.warn <= (stat_r.warn & ~w1c[2:0]) | set_warn;
			stat_r.trip <= (stat_r.trip & ~w1c[5:3]) | set_trip;
			if (any_set)
				code_r <= code_nxt;
			if (cnt_inc)
				count_r <= count_r + 1'b1;
			// Detection is independent of this disable
			share_r <= imb_s & {3{!cfg_r.dis}};
		end
	end

	// ****************
	// AXI4-Lite read path
	// ****************
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	wire ar_hs = s_axi_arvalid && s_axi_arready;
	wire [7:0] ra = s_axi_araddr;
	wire [31:0] rd_mux =
		(ra == `PCSM_OFF_CTRL) ? {29'h0, cfg_r.dis, cfg_r.action} :
		(ra == `PCSM_OFF_PWM_THR) ? {24'h0, cfg_r.pwm_thr} :
		(ra == `PCSM_OFF_WIN_THR) ? {24'h0, cfg_r.win_thr} :
		(ra == `PCSM_OFF_DUR) ? {28'h0, cfg_r.dur} :
		(ra == `PCSM_OFF_COUNT) ? 32'(count_r) :
		(ra == `PCSM_OFF_STATUS) ? {26'h0, stat_r} :
		(ra == `PCSM_OFF_MASK) ? {26'h0, mask_r} :
		(ra == `PCSM_OFF_CODE) ? {24'h0, code_r} : 32'h0;
	wire ra_ok = (ra == `PCSM_OFF_CTRL) || (ra == `PCSM_OFF_PWM_THR) ||
		(ra == `PCSM_OFF_WIN_THR) || (ra == `PCSM_OFF_DUR) ||
		(ra == `PCSM_OFF_COUNT) || (ra == `PCSM_OFF_STATUS) ||
		(ra == `PCSM_OFF_MASK) || (ra == `PCSM_OFF_CODE);
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= 2'h0;
		end else if (ar_hs) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_mux;
			rresp_r <= ra_ok ? 2'h0 : 2'h2;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// ****************
	// Outputs
	// ****************
	assign share_drive = share_r;
	assign sharing_warning = |stat_r.warn;
	assign sharing_trip = |stat_r.trip;
	assign report_code = code_r;
	assign irq = |(stat_r & mask_r);

	// ****************
	// Checks
	// ****************
	sequence s_fail_now;
		|fail;
	endsequence
	a_action_none: assert property (@(posedge mclk) disable iff (!rstn)
		(s_fail_now and (cfg_r.action == `PCSM_ACT_NONE && !wr_stat)) |=>
		stat_r == $past(stat_r))
		else $error("status changed with no action");
	a_warn_code: assert property (@(posedge mclk) disable iff (!rstn)
		fail[0] && act_warn |=> report_code == 8'd139 && stat_r.warn[0])
		else $error("wrong U warning code");
	a_trip_code_v: assert property (@(posedge mclk) disable iff (!rstn)
		fail == 3'b010 && act_trip |=> report_code == 8'd208 && sharing_trip)
		else $error("wrong V trip code");
	a_trip_code_w: assert property (@(posedge mclk) disable iff (!rstn)
		fail == 3'b100 && act_trip |=> report_code == 8'd209 && stat_r.trip[2])
		else $error("wrong W trip code");
	a_low_current: assert property (@(posedge mclk) disable iff (!rstn)
		!cur_high_s && !wr_stat |=> stat_r == $past(stat_r)) else $error("raised at low current");
	a_share_dis: assert property (@(posedge mclk) disable iff (!rstn)
		cfg_r.dis ##1 cfg_r.dis |-> share_drive == 3'h0) else $error("sharing while disabled");
	a_count_step: assert property (@(posedge mclk) disable iff (!rstn)
		!(win_tick && (|lvl1_win)) |=> count_r == $past(count_r))
		else $error("count moved without first-level error");
	a_irq_level: assert property (@(posedge mclk) disable iff (!rstn)
		irq == |(stat_r & mask_r)) else $error("irq mismatch");
	a_bresp_wait: assert property (@(posedge mclk) disable iff (!rstn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
endmodule : pcsm_top

// ===== tb.sv
`include "pcsm_params.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, rstn, cur_en;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, imb_len, report_code, exp_code;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, lfsr;
	logic [3:0] s_axi_wstrb;
	logic [2:0] imb_sel, phase_imbalance, share_drive;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic current_high, pwm_tick, win_tick, sharing_warning, sharing_trip, irq;
	logic [15:0] exp_cnt;
	logic [31:0] rst_v [8] = '{32'h2, 32'h4, 32'h3, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
	int error_cnt, total_checks, wt;

	always #4 mclk = ~mclk;

	pcsm_top #(.CW(8), .NCNT(16)) DUT (.mclk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.phase_imbalance, .current_high, .pwm_tick, .win_tick, .share_drive,
		.sharing_warning, .sharing_trip, .report_code, .irq);
	pcsm_bridge_model #(.PER(120), .WINP(4)) bridge (.mclk, .rstn, .imb_sel, .imb_len,
		.cur_en, .phase_imbalance, .current_high, .pwm_tick, .win_tick);

	// ****************
	// Helpers
	// ****************
	function automatic logic [31:0] lfsr_nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr_nx
	function automatic logic [5:0] stat_f(input int a, input int p);
		return (a == 1) ? 6'(1 << p) : (a == 2) ? 6'(8 << p) : 6'h00;
	endfunction : stat_f
	function automatic logic [7:0] code_f(input int a, input int p, input logic [7:0] old);
		return (a == 1) ? 8'h8B + 8'(p) : (a == 2) ? 8'hCF + 8'(p) : old;
	endfunction : code_f
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wrap_up;
		$display("checks=%0d errors=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	// Ready is looked at before the edge, so the handshake edge is never raced
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic pa, pw, ta, tw, bv;
		pa = 1'b1;
		pw = 1'b1;
		bv = 1'b0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (pa || pw) begin
			@(negedge mclk);
			ta = pa && s_axi_awready;
			tw = pw && s_axi_wready;
			@(posedge mclk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
		while (!bv) begin
			@(negedge mclk);
			bv = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge mclk);
		end
		s_axi_bready <= 1'b0;
	endtask : axw
	task automatic axr(input logic [7:0] a);
		logic ta, rv;
		ta = 1'b0;
		rv = 1'b0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!ta) begin
			@(negedge mclk);
			ta = s_axi_arready;
			@(posedge mclk);
		end
		s_axi_arvalid <= 1'b0;
		while (!rv) begin
			@(negedge mclk);
			rv = s_axi_rvalid;
			rd = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge mclk);
		end
		s_axi_rready <= 1'b0;
	endtask : axr
	task automatic win(input int n);
		repeat (n) begin
			@(negedge mclk iff win_tick);
			@(posedge mclk);
		end
	endtask : win
	task automatic settle;
		repeat (2) @(negedge mclk);
	endtask : settle
	task automatic burst(input logic [2:0] m);
		win(1);
		imb_sel <= m;
		win(3);
		imb_sel <= 3'h0;
		settle();
	endtask : burst
	task automatic run_case(input int act, input int ph, input logic dis);
		wt = 1 + int'(lfsr % 3);
		lfsr = lfsr_nx(lfsr);
		axw(`PCSM_OFF_PWM_THR, 32'(1 + lfsr % 4));
		lfsr = lfsr_nx(lfsr);
		axw(`PCSM_OFF_CTRL, {29'h0, dis, 2'(act)});
		axw(`PCSM_OFF_WIN_THR, 32'(wt));
		win(1);
		imb_sel <= 3'(1 << ph);
		repeat (8) @(negedge mclk);
		chk(32'(share_drive), dis ? 32'h0 : 32'(1 << ph));
		win(wt - 1);
		settle();
		chk(32'({sharing_trip, sharing_warning}), 32'h0);
		win(1);
		imb_sel <= 3'h0;
		settle();
		exp_code = code_f(act, ph, exp_code);
		exp_cnt = exp_cnt + 16'(wt);
		chk(32'({irq, sharing_trip, sharing_warning}), 32'({act == 2, act == 2, act == 1}));
		chk(32'(report_code), 32'(exp_code));
		axr(`PCSM_OFF_STATUS);
		chk(rd, 32'(stat_f(act, ph)));
		axr(`PCSM_OFF_COUNT);
		chk(rd, 32'(exp_cnt));
		axw(`PCSM_OFF_STATUS, 32'h3F);
		axr(`PCSM_OFF_STATUS);
		chk({rd[30:0], irq}, 32'h0);
	endtask : run_case

	// ****************
	// Main sequence
	// ****************
	initial begin
		mclk = 1'b0;
		rstn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		imb_sel = 3'h0;
		imb_len = 8'h50;
		cur_en = 1'b1;
		lfsr = 32'hFCB50B00;
		exp_cnt = 16'h0;
		exp_code = 8'h00;
		error_cnt = 0;
		total_checks = 0;
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			axr(8'(i * 4));
			chk(rd, (i < 8) ? rst_v[i] : 32'h0);
			chk(32'(rs), (i < 8) ? 32'h0 : 32'h2);
		end
		axw(8'h20, 32'hFFFFFFFF);
		chk(32'(rs), 32'h2);
		axw(`PCSM_OFF_MASK, 32'h38);
		// Action 3 must behave as no action
		for (int a = 0; a < 4; a++)
			for (int p = 0; p < 3; p++)
				run_case(a, p, p == 1);
		// Back to trip, so the bursts below could raise something
		axw(`PCSM_OFF_CTRL, 32'h2);
		axr(`PCSM_OFF_CTRL);
		chk(rd, 32'h2);
		// Imbalance shorter than the event duration
		axw(`PCSM_OFF_DUR, 32'h1);
		burst(3'h1);
		axr(`PCSM_OFF_COUNT);
		chk(rd, 32'(exp_cnt));
		chk(32'({sharing_trip, sharing_warning}), 32'h0);
		// Current too low to matter, first-level errors still counted
		axw(`PCSM_OFF_DUR, 32'h0);
		cur_en <= 1'b0;
		burst(3'h4);
		chk(32'({irq, sharing_trip, sharing_warning}), 32'h0);
		exp_cnt = exp_cnt + 16'h3;
		axr(`PCSM_OFF_COUNT);
		chk(rd, 32'(exp_cnt));
		wrap_up();
	end

	initial begin
		repeat (80000) @(posedge mclk);
		error_cnt++;
		wrap_up();
	end
endmodule : tb
